// *** core/sct_sdram_core.sv ***
// Device side of a synchronous DRAM: command decode, bursts, read latency pipe,
// data masking, clock suspend, power-down and self refresh, small storage array.
// Assumes pins already synchronous to mclk and a controller keeping all command spacing.
`timescale 1ns/100ps
`include "sct_params.svh"

module sct_sdram_core import sct_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Command pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [`SCT_BA_W-1:0] ba,
    input wire logic [`SCT_ADDR_W-1:0] addr,
    // Data pins
    input wire logic dqm,
    input wire logic [`SCT_DQ_W-1:0] dq_in,
    output logic [`SCT_DQ_W-1:0] dq_out,
    output logic dq_oe,
    // Status
    output logic [`SCT_BANKS-1:0] bank_open,
    output logic [2:0] read_latency,
    output logic power_down,
    output logic self_refresh,
    output logic clk_active,
    output logic wbuf_ready
);

    function automatic logic [`SCT_IDX_W-1:0] mem_idx(input logic [`SCT_BA_W-1:0] b,
                                                   input logic [`SCT_COL_W-1:0] c);
        return {b, c};
    endfunction : mem_idx

    // Storage: rows alias onto one another, only bank and column select a word
    logic [`SCT_DQ_W-1:0] mem [`SCT_MEM_WORDS];

    sct_cmd_t cmd;
    logic en;
    logic cke_q, cke_d;
    sct_pwr_t pwr_q, pwr_d;
    logic [2:0] rl_q, rl_d;
    logic [2:0] rl_field;
    logic [`SCT_BANKS-1:0] open_q, open_d;
    logic [2:0] bcnt_q, bcnt_d;
    logic bwr_q, bwr_d, bap_q, bap_d;
    logic [`SCT_BA_W-1:0] bba_q, bba_d;
    logic [`SCT_COL_W-1:0] bcol_q, bcol_d;
    logic beat_rd, beat_wr, beat_ap;
    logic [`SCT_BA_W-1:0] beat_ba;
    logic [`SCT_COL_W-1:0] beat_col;
    logic s0_vld_q, s0_vld_d, s1_vld_q, s1_vld_d;
    logic [`SCT_DQ_W-1:0] s0_q, s0_d, s1_q, s1_d;
    logic dqm_q, dqm_d;
    logic [`SCT_DQ_W-1:0] out_q, out_d;
    logic oe_q, oe_d;
    logic idle_next;
    logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
    logic [`SCT_WBUF_W-1:0] buf_in_data, buf_out_data;

    assign cmd = sct_decode(cs_n, ras_n, cas_n, we_n);
    // Commands only act on edges where clocking is enabled and the device is awake
    assign en = cke_q && (pwr_q == SCT_PWR_RUN);
    assign rl_field = addr[`SCT_RL_MSB:`SCT_RL_LSB];

    assign dq_out = out_q;
    assign dq_oe = oe_q;
    assign bank_open = open_q;
    assign read_latency = rl_q;
    assign power_down = pwr_q[1];
    assign self_refresh = pwr_q[2];
    assign clk_active = cke_q;

    // Burst sequencing and bank state
    always_comb begin
        bcnt_d = bcnt_q;
        bwr_d = bwr_q;
        bap_d = bap_q;
        bba_d = bba_q;
        bcol_d = bcol_q;
        open_d = open_q;
        rl_d = rl_q;
        beat_rd = 1'b0;
        beat_wr = 1'b0;
        beat_ap = 1'b0;
        beat_ba = bba_q;
        beat_col = bcol_q;
        if (en) begin
            if (cmd == SCT_CMD_READ || cmd == SCT_CMD_WRITE) begin
                // First beat on the command edge itself
                beat_rd = (cmd == SCT_CMD_READ);
                beat_wr = (cmd == SCT_CMD_WRITE);
                beat_ba = ba;
                beat_col = addr[`SCT_COL_W-1:0];
                bwr_d = (cmd == SCT_CMD_WRITE);
                bap_d = addr[`SCT_AP_BIT];
                bba_d = ba;
                bcol_d = addr[`SCT_COL_W-1:0] + `SCT_COL_STEP;
                bcnt_d = `SCT_BURST_LEN - `SCT_BEAT_ONE;
            end else if (cmd == SCT_CMD_PRE || cmd == SCT_CMD_BST) begin
                // Stop feeding the read pipe so it drains within the latency
                bcnt_d = 3'h0;
            end else if (bcnt_q != 3'h0) begin
                beat_rd = !bwr_q;
                beat_wr = bwr_q;
                beat_ap = bap_q && (bcnt_q == `SCT_BEAT_ONE);
                bcol_d = bcol_q + `SCT_COL_STEP;
                bcnt_d = bcnt_q - `SCT_BEAT_ONE;
            end
            case (cmd)
                SCT_CMD_ACT: open_d[ba] = 1'b1;
                SCT_CMD_PRE: begin
                    if (addr[`SCT_AP_BIT]) begin
                        open_d = '0;
                    end else begin
                        open_d[ba] = 1'b0;
                    end
                end
                SCT_CMD_MRS: begin
                    // Unsupported latencies leave the current setting in place
                    if (rl_field == `SCT_RL_TWO || rl_field == `SCT_RL_THREE) begin
                        rl_d = rl_field;
                    end
                end
                default: begin
                end
            endcase
            if (beat_ap) begin
                open_d[bba_q] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            bcnt_q <= 3'h0;
            bwr_q <= 1'b0;
            bap_q <= 1'b0;
            bba_q <= '0;
            bcol_q <= '0;
            open_q <= '0;
            rl_q <= `SCT_RL_RESET;
        end else begin
            bcnt_q <= bcnt_d;
            bwr_q <= bwr_d;
            bap_q <= bap_d;
            bba_q <= bba_d;
            bcol_q <= bcol_d;
            open_q <= open_d;
            rl_q <= rl_d;
        end
    end

    // Clock enable and power state
    always_comb begin
        cke_d = cke;
        pwr_d = pwr_q;
        idle_next = (bcnt_d == 3'h0) && !beat_rd && !s0_vld_q && !s1_vld_q;
        case (pwr_q)
            SCT_PWR_RUN: begin
                if (cke_q && !cke) begin
                    if (cmd == SCT_CMD_REF) begin
                        pwr_d = SCT_PWR_SELF;
                    end else if (idle_next) begin
                        pwr_d = SCT_PWR_DOWN;
                    end
                end
            end
            SCT_PWR_DOWN, SCT_PWR_SELF: begin
                // Exit edge: awake from the following edge on
                if (cke) begin
                    pwr_d = SCT_PWR_RUN;
                end
            end
            default: pwr_d = SCT_PWR_RUN;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cke_q <= 1'b1;
            pwr_q <= SCT_PWR_RUN;
        end else begin
            cke_q <= cke_d;
            pwr_q <= pwr_d;
        end
    end

    // Read pipe; every stage freezes while clocking is suspended
    always_comb begin
        s0_vld_d = s0_vld_q;
        s0_d = s0_q;
        s1_vld_d = s1_vld_q;
        s1_d = s1_q;
        dqm_d = dqm_q;
        out_d = out_q;
        oe_d = oe_q;
        if (cke_q) begin
            s0_vld_d = beat_rd;
            s0_d = mem[mem_idx(beat_ba, beat_col)];
            s1_vld_d = s0_vld_q;
            s1_d = s0_q;
            dqm_d = dqm;
            out_d = (rl_q == `SCT_RL_THREE) ? s1_q : s0_q;
            // Mask sampled one edge back lands on the word seen two edges later
            oe_d = ((rl_q == `SCT_RL_THREE) ? s1_vld_q : s0_vld_q) && !dqm_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s0_vld_q <= 1'b0;
            s0_q <= '0;
            s1_vld_q <= 1'b0;
            s1_q <= '0;
            dqm_q <= 1'b0;
            out_q <= '0;
            oe_q <= 1'b0;
        end else begin
            s0_vld_q <= s0_vld_d;
            s0_q <= s0_d;
            s1_vld_q <= s1_vld_d;
            s1_q <= s1_d;
            dqm_q <= dqm_d;
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    // Write path: masked words never enter the buffer
    assign buf_in_valid = beat_wr && !dqm;
    assign buf_in_data = {beat_ba, beat_col, dq_in};
    // The array has one port, so a read beat stalls the drain
    assign buf_out_ready = !beat_rd;

    sct_wbuf #(
        .WIDTH(`SCT_WBUF_W),
        .DEPTH(`SCT_WBUF_DEPTH)
    ) u_wbuf (
        .mclk(mclk),
        .srst(srst),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(buf_in_data),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );
    assign wbuf_ready = buf_in_ready;

    always_ff @(posedge mclk) begin
        if (buf_out_valid && buf_out_ready) begin
            mem[buf_out_data[`SCT_WBUF_W-1:`SCT_DQ_W]] <= buf_out_data[`SCT_DQ_W-1:0];
        end
    end

    property p_pre_hiz_rl2;
        @(posedge mclk) disable iff (srst)
        (en && cmd == SCT_CMD_PRE && rl_q == `SCT_RL_TWO && cke) ##1 cke |=> !dq_oe;
    endproperty
    a_pre_hiz_rl2: assert property (p_pre_hiz_rl2) else $error("output not floated after precharge");

    property p_pre_hiz_rl3;
        @(posedge mclk) disable iff (srst)
        (en && cmd == SCT_CMD_PRE && rl_q == `SCT_RL_THREE && cke) ##1 cke[*2] |=> !dq_oe;
    endproperty
    a_pre_hiz_rl3: assert property (p_pre_hiz_rl3) else $error("output not floated after precharge");

    property p_rd_mask;
        @(posedge mclk) disable iff (srst)
        (cke_q && dqm && cke) |-> ##2 !dq_oe;
    endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("masked read word was driven");

    property p_wr_mask;
        @(posedge mclk) disable iff (srst)
        (beat_wr && dqm) |-> !(buf_in_valid && buf_in_ready);
    endproperty
    a_wr_mask: assert property (p_wr_mask) else $error("masked write word was stored");

    property p_wr_first;
        @(posedge mclk) disable iff (srst)
        (en && cmd == SCT_CMD_WRITE && !dqm && wbuf_ready)
            |-> buf_in_valid && buf_in_data[`SCT_DQ_W-1:0] == dq_in;
    endproperty
    a_wr_first: assert property (p_wr_first) else $error("first write word not taken");

    property p_suspend;
        @(posedge mclk) disable iff (srst)
        !cke |-> ##2 ($stable(bcnt_q) && $stable(dq_oe) && $stable(dq_out));
    endproperty
    a_suspend: assert property (p_suspend) else $error("state moved while clock suspended");

    property p_pd_entry;
        @(posedge mclk) disable iff (srst)
        (pwr_q == SCT_PWR_RUN && cke_q && !cke && cmd == SCT_CMD_NOP && bcnt_q == 3'h0
            && !s0_vld_q && !s1_vld_q) |=> power_down ##1 (power_down || cke_q);
    endproperty
    a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");

    property p_pd_exit;
        @(posedge mclk) disable iff (srst)
        ((power_down || self_refresh) && cke) |=> !power_down && !self_refresh && clk_active;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("power-down exit late");

endmodule : sct_sdram_core

// *** core/sct_params.svh ***
// Named constants for the SDRAM command timing core: pin widths, mode field, burst, buffer.
// Assumes inclusion by bare name from the package and the design modules.
// Summary of operation
// - Precharge ending a read floats the data outputs within the read latency.
// - Read data mask floats the output word sampled 2 clocks after the mask.
// - Write data word with mask asserted on its own edge is discarded.
// - First write word is taken on the same edge as the write command.
// - Clock enable sampled low suspends internal clocking from the next edge.
// - Power-down is entered within 1 clock of its entry condition being sampled.
// - Clock enable raised ends power-down; it takes effect one clock later.
`ifndef SCT_PARAMS_SVH
`define SCT_PARAMS_SVH

`define SCT_DQ_W 16
`define SCT_ADDR_W 12
`define SCT_BA_W 2
`define SCT_BANKS 4
`define SCT_COL_W 4
`define SCT_IDX_W 6
`define SCT_MEM_WORDS 64
`define SCT_WBUF_W 22
`define SCT_WBUF_DEPTH 4

`define SCT_RL_LSB 4
`define SCT_RL_MSB 6
`define SCT_RL_TWO 3'h2
`define SCT_RL_THREE 3'h3
`define SCT_RL_RESET 3'h3
`define SCT_AP_BIT 10

`define SCT_BURST_LEN 3'h4
`define SCT_BEAT_ONE 3'h1
`define SCT_COL_STEP 4'h1

`endif

// *** core/sct_pkg.sv ***
// Types shared by the SDRAM command timing core: commands and power states.
// Assumes the constants header is on the include path.
`include "sct_params.svh"

package sct_pkg;

    typedef enum logic [7:0] {
        SCT_CMD_NOP = 8'h01,
        SCT_CMD_ACT = 8'h02,
        SCT_CMD_READ = 8'h04,
        SCT_CMD_WRITE = 8'h08,
        SCT_CMD_PRE = 8'h10,
        SCT_CMD_REF = 8'h20,
        SCT_CMD_MRS = 8'h40,
        SCT_CMD_BST = 8'h80
    } sct_cmd_t;

    typedef enum logic [2:0] {
        SCT_PWR_RUN = 3'h1,
        SCT_PWR_DOWN = 3'h2,
        SCT_PWR_SELF = 3'h4
    } sct_pwr_t;

    function automatic sct_cmd_t sct_decode(input logic cs_n, input logic ras_n,
                                            input logic cas_n, input logic we_n);
        sct_cmd_t c;
        c = SCT_CMD_NOP;
        if (!cs_n) begin
            case ({ras_n, cas_n, we_n})
                3'h3: c = SCT_CMD_ACT;
                3'h5: c = SCT_CMD_READ;
                3'h4: c = SCT_CMD_WRITE;
                3'h2: c = SCT_CMD_PRE;
                3'h1: c = SCT_CMD_REF;
                3'h0: c = SCT_CMD_MRS;
                3'h6: c = SCT_CMD_BST;
                default: c = SCT_CMD_NOP;
            endcase
        end
        return c;
    endfunction : sct_decode

endpackage : sct_pkg

// *** core/sct_wbuf.sv ***
// Small FIFO between write data capture and the storage array.
// Assumes one clock and a synchronous active-high reset; depth a power of two.
`timescale 1ns/100ps

module sct_wbuf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic rdy_q, rdy_d;
    logic push, pop;

    assign in_ready = rdy_q;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rp_q];

    always_comb begin
        push = in_valid && rdy_q;
        pop = out_valid && out_ready;
        wp_d = push ? PW'(wp_q + 1'b1) : wp_q;
        rp_d = pop ? PW'(rp_q + 1'b1) : rp_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = CW'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = CW'(cnt_q - 1'b1);
        end
        // Ready is registered so the core can present it straight from a flop
        rdy_d = (cnt_d != FULL);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

endmodule : sct_wbuf

// *** sim/sct_ctl_model.sv ***
// Controller-side model: drives command and write-data pins, keeping command spacing.
// Assumes it shares mclk and srst with the device core; the bench calls its tasks.
`timescale 1ns/100ps
`include "sct_params.svh"

module sct_ctl_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Command pins
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [`SCT_BA_W-1:0] ba,
    output logic [`SCT_ADDR_W-1:0] addr,
    // Data pins
    output logic dqm,
    output logic [`SCT_DQ_W-1:0] dq_in
);
    int cyc = 0;
    int act_ok = 0;
    int cmd_ok = 0;
    int rw_ok [`SCT_BANKS];
    int pre_ok [`SCT_BANKS];
    int dal_ok [`SCT_BANKS];
    // Row and spare address bits; the bench loads them from its random source
    logic [11:0] rnd_row = 12'h000;

    initial begin
        {cke, cs_n, ras_n, cas_n, we_n, dqm} = 6'h3e;
        ba = 2'h0;
        addr = 12'h000;
        dq_in = 16'h5a5a;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
    end

    // Holds off until the take edge reaches need, then drives the command for one cycle
    task automatic send(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
                        input logic [15:0] d, input logic m, input logic ck, input int need);
        do @(posedge mclk); while (cyc + 1 < need || cyc + 1 < cmd_ok);
        {cs_n, ras_n, cas_n, we_n} <= {1'b0, c};
        ba <= b;
        addr <= a;
        dq_in <= d;
        dqm <= m;
        cke <= ck;
        @(posedge mclk);
        cs_n <= 1'b1;
        // Released lines flip so a stale value cannot pass for a fresh one
        ba <= ~b;
        addr <= ~a;
    endtask : send

    task automatic act(input logic [1:0] b);
        int need;
        // Held off as if every earlier write had closed its bank by itself
        need = (act_ok > dal_ok[b]) ? act_ok : dal_ok[b];
        send(3'h3, b, rnd_row, ~dq_in, 1'b0, 1'b1, need);
        act_ok = cyc + 2;
        rw_ok[b] = cyc + 3;
    endtask : act

    task automatic mrs(input logic [2:0] v);
        send(3'h0, 2'h0, {5'h00, v, 4'h0}, ~dq_in, 1'b0, 1'b1, 0);
        act_ok = cyc + 3;
    endtask : mrs

    task automatic rd(input logic [1:0] b, input logic [3:0] c, input logic ap);
        send(3'h5, b, {rnd_row[11], ap, rnd_row[9:4], c}, ~dq_in, 1'b0, 1'b1,
             rw_ok[b]);
    endtask : rd

    task automatic pre(input logic [1:0] b);
        send(3'h2, b, {rnd_row[11], 1'b0, rnd_row[9:0]}, ~dq_in, 1'b0, 1'b1,
             pre_ok[b]);
    endtask : pre

    task automatic wr(input logic [1:0] b, input logic [3:0] c, input logic [63:0] w,
                      input logic [3:0] m);
        send(3'h4, b, {rnd_row[11], 1'b0, rnd_row[9:4], c}, w[15:0], m[0], 1'b1,
             rw_ok[b]);
        for (int i = 1; i < 4; i++) begin
            dq_in <= w[16*i +: 16];
            dqm <= m[i];
            @(posedge mclk);
        end
        dq_in <= ~w[63:48];
        dqm <= 1'b0;
        pre_ok[b] = cyc + 2;
        dal_ok[b] = cyc + 5;
    endtask : wr

    task automatic self_ref();
        send(3'h1, 2'h0, 12'h000, ~dq_in, 1'b0, 1'b0, 0);
    endtask : self_ref

    task automatic wake();
        // Treated as though the clock had been stopped while asleep
        repeat (200) @(posedge mclk);
        cke <= 1'b1;
        cmd_ok = cyc + 11;
    endtask : wake

    task automatic set_cke(input logic v);
        cke <= v;
    endtask : set_cke

    task automatic set_mask(input logic v);
        dqm <= v;
    endtask : set_mask
endmodule : sct_ctl_model

// *** sim/tb.sv ***
// Self-checking bench for the SDRAM command timing core against a word-array model.
// Assumes the controller model keeps all command spacing; one 50 MHz clock.
`timescale 1ns/100ps
`include "sct_params.svh"

module tb;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic cke, cs_n, ras_n, cas_n, we_n, dqm;
    logic [`SCT_BA_W-1:0] ba;
    logic [`SCT_ADDR_W-1:0] addr;
    logic [`SCT_DQ_W-1:0] dq_in, dq_out;
    logic dq_oe, power_down, self_refresh, clk_active, wbuf_ready;
    logic [`SCT_BANKS-1:0] bank_open;
    logic [2:0] read_latency;
    logic [15:0] mem [64];
    logic [15:0] seed = 16'h000f;
    logic [2:0] rl = 3'h3;
    logic [2:0] mv [4] = '{3'h5, 3'h2, 3'h7, 3'h3};
    int fails = 0;
    int n_tests = 0;

    always #10 mclk = ~mclk;

    sct_ctl_model ctl_u (.mclk(mclk), .srst(srst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in));

    sct_sdram_core dut_u (.mclk(mclk), .srst(srst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .bank_open(bank_open), .read_latency(read_latency),
        .power_down(power_down), .self_refresh(self_refresh), .clk_active(clk_active),
        .wbuf_ready(wbuf_ready));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    // Masked beats leave the model word untouched
    task automatic wr_do(input logic [1:0] b, input logic [3:0] c, input logic [3:0] m);
        logic [63:0] w;
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            w[16*i +: 16] = seed;
            if (!m[i]) mem[{b, c + 4'(i)}] = seed;
        end
        ctl_u.rnd_row = seed[11:0];
        ctl_u.wr(b, c, w, m);
        // Let the write buffer drain before any read
        repeat (3) @(posedge mclk);
    endtask : wr_do

    // Mask for beat i must be sampled two edges before that beat is sampled
    task automatic rd_chk(input logic [1:0] b, input logic [3:0] c, input logic [3:0] mk);
        int i;
        seed = lfsr(seed);
        ctl_u.rnd_row = seed[11:0];
        ctl_u.rd(b, c, 1'b0);
        for (int t = 0; t < rl + 3; t++) begin
            i = t + 3 - rl;
            ctl_u.set_mask(i >= 0 && i < 4 && mk[i]);
            #1;
            i = t + 1 - rl;
            if (i >= 0) begin
                chk(16'(dq_oe), 16'(!mk[i]), "drive enable");
                if (!mk[i]) chk(dq_out, mem[{b, c + 4'(i)}], "read word");
            end
            @(posedge mclk);
        end
    endtask : rd_chk

    initial begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        #1;
        chk(16'({dq_oe, bank_open, read_latency, power_down, self_refresh, clk_active,
            wbuf_ready}), 16'h0033, "reset state");
        for (int k = 0; k < 4; k++) begin
            ctl_u.mrs(mv[k]);
            if (mv[k] == 3'h2 || mv[k] == 3'h3) rl = mv[k];
            #1;
            chk(16'(read_latency), 16'(rl), "latency field");
        end
        ctl_u.act(2'h1);
        ctl_u.act(2'h2);
        #1;
        chk(16'(bank_open), 16'h0006, "open banks");
        wr_do(2'h1, 4'he, 4'h0);
        wr_do(2'h1, 4'he, 4'h4);
        wr_do(2'h2, 4'h0, 4'h0);
        for (int k = 2; k < 4; k++) begin
            ctl_u.mrs(3'(k));
            rl = 3'(k);
            rd_chk(2'h1, 4'he, k == 2 ? 4'h4 : 4'h9);
            rd_chk(2'h2, 4'h0, 4'h0);
            // Precharge cuts a burst short, once in each latency
            ctl_u.rd(2'h2, 4'h0, 1'b0);
            ctl_u.pre(2'h2);
            repeat (rl - 1) @(posedge mclk);
            #1;
            chk(16'({dq_oe, bank_open[2]}), 16'h0000, "floated after precharge");
            ctl_u.act(2'h2);
        end
        repeat (4) @(posedge mclk);
        ctl_u.rd(2'h1, 4'he, 1'b0);
        @(posedge mclk);
        ctl_u.set_cke(1'b0);
        @(posedge mclk);
        ctl_u.set_cke(1'b1);
        #1;
        chk(16'({clk_active, dq_oe}), 16'h0001, "suspend flag");
        chk(dq_out, mem[{2'h1, 4'he}], "first word");
        @(posedge mclk);
        #1;
        chk(dq_out, mem[{2'h1, 4'he}], "held word");
        chk(16'(power_down), 16'h0000, "no power-down in burst");
        @(posedge mclk);
        #1;
        chk(dq_out, mem[{2'h1, 4'hf}], "resumed word");
        repeat (6) @(posedge mclk);
        ctl_u.set_cke(1'b0);
        @(posedge mclk);
        #1;
        chk(16'({power_down, clk_active}), 16'h0002, "power-down entry");
        repeat (3) @(posedge mclk);
        ctl_u.set_cke(1'b1);
        @(posedge mclk);
        #1;
        chk(16'({power_down, clk_active}), 16'h0001, "power-down exit");
        ctl_u.self_ref();
        #1;
        chk(16'(self_refresh), 16'h0001, "self refresh entry");
        ctl_u.wake();
        @(posedge mclk);
        #1;
        chk(16'(self_refresh), 16'h0000, "self refresh exit");
        rd_chk(2'h1, 4'he, 4'h0);
        // Auto precharge closes bank 1 on its last beat; bank 2 stays open
        ctl_u.rd(2'h1, 4'h2, 1'b1);
        repeat (3) @(posedge mclk);
        #1;
        chk(16'(bank_open), 16'h0004, "auto precharge close");
        test_done();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        test_done();
    end
endmodule : tb
